// >>> rtl/tcdma_top.sv
// Two-channel transfer engine with read/write split by a data FIFO
`timescale 1ns/10ps

module tcdma_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } tcdma_fifo_st_t;
    tcdma_fifo_st_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    // Handshakes on both sides
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        in_ready = (st.cnt != DEPTH[AW:0]);
        out_valid = (st.cnt != '0);
        out_data = mem[st.rp];
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // Pointer state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule : tcdma_fifo

module tcdma_top (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic controller_enable,
    input wire logic priority_scheme_select,
    input wire logic [15:0] upper_address_limit,
    input wire logic [15:0] lower_address_limit,
    input wire tcdma_pkg::tcdma_cfg_t cfg [2],
    input wire logic [127:0] irq_sources,
    input wire logic cpu_needs_bus,
    input wire logic [15:0] rd_data,
    output logic rd_req,
    output logic [15:0] rd_addr,
    output logic wr_req,
    output logic [15:0] wr_addr,
    output logic [15:0] wr_data,
    output logic [1:0] wr_byte_en,
    output logic [15:0] src_addr [2],
    output logic [15:0] dst_addr [2],
    output logic [15:0] transaction_counter [2],
    output tcdma_pkg::tcdma_flags_t channel_interrupt_register [2],
    output logic [1:0] channel_zero_one_irq,
    output logic [1:0] busy
);
    localparam int FW = $bits(tcdma_pkg::tcdma_word_t);

    typedef struct packed {
        tcdma_pkg::tcdma_state_t fsm;
        logic cur;
        logic rr_last;
        logic [1:0] active;
        logic [1:0] pend;
        logic [1:0] trig_d;
        logic [1:0] [15:0] src;
        logic [1:0] [15:0] dst;
        logic [1:0] [15:0] cnt;
        logic [1:0] [3:0] flags;
        logic [1:0] irq;
        logic rd_req;
        logic [15:0] rd_addr;
        logic wr_req;
        logic [15:0] wr_addr;
        logic [15:0] wr_data;
        logic [1:0] wr_be;
        tcdma_pkg::tcdma_word_t hold;
    } tcdma_st_t;
    tcdma_st_t st, next_st;

    tcdma_pkg::tcdma_word_t f_in, f_out;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [1:0] trig_now;

    // Trigger select per channel; codes index the source vector directly
    for (genvar c = 0; c < tcdma_pkg::NCH; c++) begin : g_trig
        assign trig_now[c] = irq_sources[cfg[c].trigger_select];
    end

    // Write side drains the FIFO while the CPU does not need the bus
    assign f_out_ready = !cpu_needs_bus && !st.wr_req;

    tcdma_fifo #(.WIDTH(FW), .DEPTH(tcdma_pkg::FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_data(f_in),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .out_data(f_out),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready)
    );

    // Next address per addressing mode
    function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m,
                                         input logic bsz);
        logic [15:0] d;
        d = bsz ? 16'h0001 : 16'h0002;
        case (m)
            tcdma_pkg::AM_INC: step = a + d;
            tcdma_pkg::AM_DEC: step = a - d;
            default: step = a; // fixed and indirect hold the base
        endcase
    endfunction

    // Limit check only in RAM area
    function automatic logic out_of_lim(input logic [15:0] a, input logic [15:0] lo,
                                        input logic [15:0] hi);
        out_of_lim = (a >= tcdma_pkg::RAM_START) && ((a < lo) || (a > hi));
    endfunction

    // Channel scheduling, read issue and bookkeeping
    always_comb begin
        logic c;
        logic [1:0] req;
        logic pick;
        logic bad;
        logic last;
        next_st = st;
        c = st.cur;
        req = '0;
        pick = 1'b0;
        bad = 1'b0;
        last = 1'b0;
        next_st.rd_req = 1'b0;
        f_in = st.hold;
        f_in_valid = 1'b0;
        for (int i = 0; i < tcdma_pkg::NCH; i++) begin
            next_st.trig_d[i] = trig_now[i];
            // Start on rising trigger or software start; a later clear in the same cycle wins over set
            if (cfg[i].enable && (trig_now[i] && !st.trig_d[i] || cfg[i].sw_request)) begin
                next_st.pend[i] = 1'b1;
            end
            if (!cfg[i].enable) begin
                next_st.src[i] = cfg[i].src_start;
                next_st.dst[i] = cfg[i].dst_start;
                next_st.cnt[i] = cfg[i].count_start;
                next_st.pend[i] = 1'b0;
                next_st.active[i] = 1'b0;
            end
            req[i] = next_st.pend[i] && cfg[i].enable;
        end
        // Fixed favours channel 0; round robin rotates after a collision
        if (req == 2'b11) begin
            pick = priority_scheme_select ? st.rr_last : 1'b0;
        end else begin
            pick = req[1] && !req[0];
        end
        case (st.fsm)
            tcdma_pkg::ST_IDLE: begin
                if (req != 2'b00 && !cpu_needs_bus && f_in_ready) begin
                    next_st.cur = pick;
                    // Rotation only advances on a collision; channel 0 wins the first
                    if (req == 2'b11) begin
                        next_st.rr_last = !pick;
                    end
                    c = pick;
                    bad = out_of_lim(st.src[c], lower_address_limit, upper_address_limit)
                        || (!cfg[c].null_write
                        && out_of_lim(st.dst[c], lower_address_limit, upper_address_limit));
                    if (bad) begin
                        next_st.pend[c] = 1'b0; // transaction ends
                        next_st.active[c] = 1'b0;
                        // Only RAM-area addresses can be below the lower limit
                        if ((st.src[c] >= tcdma_pkg::RAM_START && st.src[c] < lower_address_limit)
                            || (!cfg[c].null_write && st.dst[c] >= tcdma_pkg::RAM_START
                            && st.dst[c] < lower_address_limit)) begin
                            next_st.flags[c][2] = 1'b1;
                        end else begin
                            next_st.flags[c][3] = 1'b1;
                        end
                        next_st.irq[c] = 1'b1;
                    end else begin
                        next_st.rd_req = 1'b1; // any area to any area
                        next_st.rd_addr = st.src[c];
                        next_st.active[c] = 1'b1;
                        next_st.fsm = tcdma_pkg::ST_READ;
                    end
                end
            end
            tcdma_pkg::ST_READ: begin
                next_st.fsm = tcdma_pkg::ST_WAIT;
            end
            tcdma_pkg::ST_WAIT: begin
                // Read data returned: queue the write
                f_in.addr = st.dst[c];
                f_in.byte_size = cfg[c].byte_size;
                f_in.upper_lane = st.dst[c][0];
                f_in.null_write = cfg[c].null_write;
                f_in.data = (cfg[c].byte_size && st.src[c][0]) ? {rd_data[15:8], rd_data[15:8]}
                          : {rd_data[7:0] & {8{cfg[c].byte_size}} | rd_data[15:8]
                             & {8{!cfg[c].byte_size}}, rd_data[7:0]};
                f_in_valid = 1'b1;
                next_st.src[c] = step(st.src[c], cfg[c].src_mode, cfg[c].byte_size);
                next_st.dst[c] = step(st.dst[c], cfg[c].dst_mode, cfg[c].byte_size);
                next_st.cnt[c] = st.cnt[c] - 16'h0001;
                if (cfg[c].half_en && st.cnt[c] - 16'h0001 == cfg[c].count_start >> 1) begin
                    next_st.flags[c][0] = 1'b1;
                    next_st.irq[c] = 1'b1;
                end
                last = (st.cnt[c] == 16'h0001);
                // One-shot forms end after one move; continuous at count end
                if (last || !cfg[c].tr_mode[1]) begin
                    next_st.pend[c] = cfg[c].tr_mode[1] ? 1'b0 : 1'b0;
                    next_st.active[c] = 1'b0;
                end
                if (last) begin
                    next_st.flags[c][1] = 1'b1;
                    next_st.irq[c] = 1'b1;
                    if (cfg[c].reload || cfg[c].tr_mode[0]) begin
                        next_st.src[c] = cfg[c].src_start;
                        next_st.dst[c] = cfg[c].dst_start;
                        next_st.cnt[c] = cfg[c].count_start;
                    end
                end
                next_st.fsm = tcdma_pkg::ST_IDLE;
            end
            default: next_st.fsm = tcdma_pkg::ST_IDLE;
        endcase
        // Write issue from FIFO head
        next_st.wr_req = f_out_valid && f_out_ready && !f_out.null_write;
        next_st.wr_addr = f_out.addr;
        next_st.wr_data = f_out.data;
        next_st.wr_be = !f_out.byte_size ? 2'h3 : (f_out.upper_lane ? 2'h2 : 2'h1);
        for (int i = 0; i < tcdma_pkg::NCH; i++) begin
            next_st.flags[i] = next_st.flags[i];
        end
        // Global disable returns to idle and clears pend, active and rd_req; queued FIFO writes still drain
        if (!controller_enable) begin
            next_st.fsm = tcdma_pkg::ST_IDLE;
            next_st.pend = '0;
            next_st.active = '0;
            next_st.rd_req = 1'b0;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    always_comb begin
        rd_req = st.rd_req;
        rd_addr = st.rd_addr;
        wr_req = st.wr_req;
        wr_addr = st.wr_addr;
        wr_data = st.wr_data;
        wr_byte_en = st.wr_be;
        channel_zero_one_irq = st.irq;
        busy = st.active;
        for (int i = 0; i < tcdma_pkg::NCH; i++) begin
            src_addr[i] = st.src[i];
            dst_addr[i] = st.dst[i];
            transaction_counter[i] = st.cnt[i];
            channel_interrupt_register[i] = st.flags[i];
        end
    end
endmodule : tcdma_top

// >>> pkg/tcdma_pkg.sv
// Constants, types and encodings for the two-channel transfer engine
package tcdma_pkg;

    // =====================================================
    // Sizes and address map
    localparam int NCH = 2;
    localparam int FIFO_DEPTH = 16;
    localparam logic [15:0] RAM_START = 16'h0800;
    localparam int CTRL_SIZE_BIT = 1;

    // =====================================================
    // Trigger select codes
    localparam logic [6:0] TRG_UART_TX = 7'h44;
    localparam logic [6:0] TRG_UART_RX = 7'h45;
    localparam logic [6:0] TRG_UART_ERR = 7'h46;
    localparam logic [6:0] TRG_CH1 = 7'h4F;
    localparam logic [6:0] TRG_CH0 = 7'h50;
    localparam logic [6:0] TRG_ADC = 7'h51;
    localparam logic [6:0] TRG_SPI1_RX = 7'h26;
    localparam logic [6:0] TRG_SPI1_TX = 7'h27;
    localparam logic [6:0] TRG_SPI1_GEN = 7'h28;
    localparam logic [6:0] TRG_SPI2_RX = 7'h23;
    localparam logic [6:0] TRG_SPI2_TX = 7'h24;
    localparam logic [6:0] TRG_SPI2_GEN = 7'h25;

    // =====================================================
    // Modes
    localparam logic [1:0] TR_ONESHOT = 2'h0;
    localparam logic [1:0] TR_REP_ONESHOT = 2'h1;
    localparam logic [1:0] TR_CONT = 2'h2;
    localparam logic [1:0] TR_REP_CONT = 2'h3;
    localparam logic [1:0] AM_FIXED = 2'h0;
    localparam logic [1:0] AM_INC = 2'h1;
    localparam logic [1:0] AM_DEC = 2'h2;
    localparam logic [1:0] AM_IND = 2'h3;

    // Control reset: word size (bit 1 set), disabled
    localparam logic [15:0] CTRL_RESET = 16'h0002;

    // =====================================================
    // Per-channel configuration from software
    typedef struct packed {
        logic enable;
        logic byte_size;
        logic [1:0] tr_mode;
        logic [1:0] src_mode;
        logic [1:0] dst_mode;
        logic null_write;
        logic reload;
        logic sw_request;
        logic half_en;
        logic [6:0] trigger_select;
        logic [15:0] src_start;
        logic [15:0] dst_start;
        logic [15:0] count_start;
    } tcdma_cfg_t;

    // Per-channel interrupt flags
    typedef struct packed {
        logic high;
        logic low;
        logic done;
        logic half;
    } tcdma_flags_t;

    // One data move through the buffer
    typedef struct packed {
        logic [15:0] addr;
        logic byte_size;
        logic upper_lane;
        logic null_write;
        logic [15:0] data;
    } tcdma_word_t;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WAIT} tcdma_state_t;

endpackage : tcdma_pkg

// >>> dv/tcdma_top_assertions.sv
// Port checks for the transfer engine
`timescale 1ns/10ps
module tcdma_top_assertions (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic controller_enable,
    input wire logic [15:0] upper_address_limit,
    input wire logic [15:0] lower_address_limit,
    input wire logic cpu_needs_bus,
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic [15:0] wr_addr,
    input wire logic [1:0] wr_byte_en,
    input wire logic [1:0] channel_zero_one_irq,
    input wire logic [1:0] busy
);
    // ======================================================
    // Clocking and multi-step sequences
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);
    sequence s_cpu_hold;
        cpu_needs_bus ##1 cpu_needs_bus;
    endsequence
    sequence s_off;
        !controller_enable ##1 !controller_enable;
    endsequence
    // ======================================================
    // Bus yield, abort, pulse widths, lanes, limits, sticky irq
    a_cpu_yield: assert property (s_cpu_hold |-> !rd_req)
        else $error("read issued while cpu holds the bus");
    a_off_idle: assert property (s_off |-> busy == 2'b00 && !rd_req)
        else $error("channel busy while controller off");
    a_busy_drop: assert property ($fell(controller_enable) |-> ##[1:2] busy == 2'b00)
        else $error("disable did not stop channels");
    a_rd_pulse: assert property (rd_req |=> !rd_req)
        else $error("read request too long");
    a_wr_pulse: assert property (wr_req |=> !wr_req)
        else $error("write request too long");
    a_lane_pick: assert property (wr_req && wr_byte_en != 2'b11
        |-> wr_byte_en == {wr_addr[0], !wr_addr[0]}) else $error("byte lane wrong");
    a_ram_window: assert property (wr_req && wr_addr >= tcdma_pkg::RAM_START
        |-> wr_addr >= lower_address_limit && wr_addr <= upper_address_limit)
        else $error("write outside limits");
    a_irq_hold: assert property ($rose(channel_zero_one_irq[0]) |=> channel_zero_one_irq[0] [*3])
        else $error("channel irq dropped");
endmodule : tcdma_top_assertions

bind tcdma_top tcdma_top_assertions tcdma_top_assertions_inst (
    .ref_clk(ref_clk), .rstn(rstn), .controller_enable(controller_enable),
    .upper_address_limit(upper_address_limit), .lower_address_limit(lower_address_limit),
    .cpu_needs_bus(cpu_needs_bus), .rd_req(rd_req), .wr_req(wr_req), .wr_addr(wr_addr),
    .wr_byte_en(wr_byte_en), .channel_zero_one_irq(channel_zero_one_irq), .busy(busy)
);

// >>> dv/tcdma_mem.sv
// Data space model answering the engine's reads and writes
`timescale 1ns/10ps
module tcdma_mem (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic rd_req,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rd_data,
    input wire logic wr_req,
    input wire logic [15:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [1:0] wr_byte_en
);
    logic [15:0] mem [32768];
    logic hold = 1'b0;
    logic [1:0] last_be = 2'h0;
    int wr_count = 0;
    initial rd_data = 16'h0000;
    // Read word stands two cycles, then toggles so stale data never matches
    always @(posedge ref_clk) begin
        hold <= rd_req;
        if (rd_req) rd_data <= {rd_addr[15:1], 1'b0} ^ 16'h5A3C;
        else if (!hold) rd_data <= ~rd_data;
    end
    // Only enabled lanes are stored
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_count <= 0;
        end else if (wr_req) begin
            if (wr_byte_en[0]) mem[wr_addr[15:1]][7:0] <= wr_data[7:0];
            if (wr_byte_en[1]) mem[wr_addr[15:1]][15:8] <= wr_data[15:8];
            last_be <= wr_byte_en;
            wr_count <= wr_count + 1;
        end
    end
endmodule : tcdma_mem

// >>> dv/tcdma_test.sv
// Self-checking bench for the two-channel transfer engine
`timescale 1ns/10ps
module tcdma_test;
    logic ref_clk, rstn, controller_enable, priority_scheme_select, cpu_needs_bus, rd_req, wr_req;
    logic [15:0] upper_address_limit, lower_address_limit, rd_data, rd_addr, wr_addr, wr_data;
    logic [127:0] irq_sources;
    logic [1:0] wr_byte_en, channel_zero_one_irq, busy;
    logic [15:0] src_addr [2], dst_addr [2], transaction_counter [2];
    tcdma_pkg::tcdma_cfg_t cfg [2];
    tcdma_pkg::tcdma_flags_t channel_interrupt_register [2];
    logic [6:0] codes [12] = '{7'h44, 7'h45, 7'h46, 7'h4F, 7'h50, 7'h51,
                               7'h26, 7'h27, 7'h28, 7'h23, 7'h24, 7'h25};
    int error_cnt = 0;
    int num_checks = 0;
    int cycles = 0;
    // ======================================================
    // Design and far-side model
    tcdma_top tcdma_top_inst (
        .ref_clk(ref_clk), .rstn(rstn), .controller_enable(controller_enable),
        .priority_scheme_select(priority_scheme_select),
        .upper_address_limit(upper_address_limit), .lower_address_limit(lower_address_limit),
        .cfg(cfg), .irq_sources(irq_sources), .cpu_needs_bus(cpu_needs_bus),
        .rd_data(rd_data), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_byte_en(wr_byte_en), .src_addr(src_addr),
        .dst_addr(dst_addr), .transaction_counter(transaction_counter),
        .channel_interrupt_register(channel_interrupt_register),
        .channel_zero_one_irq(channel_zero_one_irq), .busy(busy)
    );
    tcdma_mem tcdma_mem_inst (
        .ref_clk(ref_clk), .rstn(rstn), .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_byte_en(wr_byte_en)
    );
    // Clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Hang limit
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    // ======================================================
    // Shared helpers
    function automatic logic [15:0] pat(input logic [15:0] a);
        return {a[15:1], 1'b0} ^ 16'h5A3C;
    endfunction : pat
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        if (error_cnt == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task automatic rst_pulse();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
    endtask : rst_pulse
    // Program a channel disabled so start values load, then enable it
    task automatic setup(input int ch, input logic bsz, input logic [15:0] s,
                         input logic [15:0] d, input logic [15:0] n, input logic [6:0] sel);
        tcdma_pkg::tcdma_cfg_t c;
        c = '0;
        c.byte_size = bsz;
        c.tr_mode = tcdma_pkg::TR_CONT;
        c.src_mode = tcdma_pkg::AM_INC;
        c.dst_mode = tcdma_pkg::AM_INC;
        c.half_en = 1'b1;
        c.trigger_select = sel;
        c.src_start = s;
        c.dst_start = d;
        c.count_start = n;
        @(posedge ref_clk);
        cfg[ch] <= c;
        c.enable = 1'b1;
        @(posedge ref_clk);
        cfg[ch] <= c;
    endtask : setup
    task automatic kick(input logic [1:0] m);
        @(posedge ref_clk);
        cfg[0].sw_request <= m[0];
        cfg[1].sw_request <= m[1];
        @(posedge ref_clk);
        cfg[0].sw_request <= 1'b0;
        cfg[1].sw_request <= 1'b0;
    endtask : kick
    task automatic wait_writes(input int n);
        for (int i = 0; i < 200 && tcdma_mem_inst.wr_count < n; i++) @(negedge ref_clk);
        check("writes", 16'(tcdma_mem_inst.wr_count), 16'(n));
    endtask : wait_writes
    task automatic wait_rd(output logic [15:0] a);
        for (int i = 0; i < 100 && rd_req !== 1'b1; i++) @(negedge ref_clk);
        a = rd_addr;
    endtask : wait_rd
    // ======================================================
    // Scenarios
    task automatic t_word();
        setup(0, 1'b0, 16'h0100, 16'h0A00, 16'h0002, 7'h00);
        kick(2'b01);
        wait_writes(2);
        check("word 0", tcdma_mem_inst.mem[15'h0500], pat(16'h0100));
        check("word 1", tcdma_mem_inst.mem[15'h0501], pat(16'h0102));
        check("half", 16'(channel_interrupt_register[0].half), 16'h0001);
        check("count", transaction_counter[0], 16'h0000);
        check("src", src_addr[0], 16'h0104);
        check("dst", dst_addr[0], 16'h0A04);
        check("irq", {14'h0000, channel_zero_one_irq}, 16'h0001);
    endtask : t_word
    task automatic t_byte();
        logic [15:0] e;
        rst_pulse();
        check("idle", {14'h0000, busy}, 16'h0000);
        setup(1, 1'b1, 16'h0101, 16'h0A04, 16'h0001, 7'h00);
        kick(2'b10);
        wait_writes(1);
        e = pat(16'h0100);
        check("byte", {8'h00, tcdma_mem_inst.mem[15'h0502][7:0]}, {8'h00, e[15:8]});
        check("lanes", {14'h0000, tcdma_mem_inst.last_be}, 16'h0001);
    endtask : t_byte
    task automatic t_trig();
        foreach (codes[i]) begin
            setup(0, 1'b0, 16'h0100, 16'h0A00, 16'h0001, codes[i]);
            @(posedge ref_clk);
            irq_sources[codes[i]] <= 1'b1;
            @(posedge ref_clk);
            irq_sources[codes[i]] <= 1'b0;
            wait_writes(i + 2);
        end
    endtask : t_trig
    task automatic t_limit();
        rst_pulse();
        setup(1, 1'b0, 16'h0100, 16'h0F00, 16'h0001, 7'h00);
        setup(0, 1'b0, 16'h0100, 16'h0880, 16'h0001, 7'h00);
        kick(2'b11);
        repeat (6) @(negedge ref_clk);
        check("high", 16'(channel_interrupt_register[1].high), 16'h0001);
        check("low", 16'(channel_interrupt_register[0].low), 16'h0001);
        check("refused", 16'(tcdma_mem_inst.wr_count), 16'h0000);
        setup(0, 1'b0, 16'h0100, 16'h0200, 16'h0001, 7'h00);
        kick(2'b01);
        wait_writes(1);
        check("sfr", tcdma_mem_inst.mem[15'h0100], pat(16'h0100));
    endtask : t_limit
    task automatic t_cpu();
        @(posedge ref_clk);
        cpu_needs_bus <= 1'b1;
        setup(0, 1'b0, 16'h0102, 16'h0A06, 16'h0001, 7'h00);
        kick(2'b01);
        repeat (6) @(negedge ref_clk);
        check("held", 16'(tcdma_mem_inst.wr_count), 16'h0001);
        @(posedge ref_clk);
        cpu_needs_bus <= 1'b0;
        wait_writes(2);
    endtask : t_cpu
    // Colliding software starts; the first read shows who won
    task automatic collide(input logic rr, input logic [15:0] exp);
        logic [15:0] a;
        @(posedge ref_clk);
        priority_scheme_select <= rr;
        setup(0, 1'b0, 16'h0100, 16'h0A00, 16'h0001, 7'h00);
        setup(1, 1'b0, 16'h0300, 16'h0A10, 16'h0001, 7'h00);
        kick(2'b11);
        wait_rd(a);
        check("winner", a, exp);
        wait_writes(tcdma_mem_inst.wr_count + 2);
    endtask : collide
    task automatic t_abort();
        logic [15:0] a;
        setup(0, 1'b0, 16'h0100, 16'h0A00, 16'h0008, 7'h00);
        kick(2'b01);
        wait_rd(a);
        @(posedge ref_clk);
        controller_enable <= 1'b0;
        repeat (2) @(negedge ref_clk);
        check("abort", {14'h0000, busy}, 16'h0000);
        @(posedge ref_clk);
        controller_enable <= 1'b1;
    endtask : t_abort
    // Main sequence
    initial begin
        rstn = 1'b0;
        controller_enable = 1'b1;
        priority_scheme_select = 1'b0;
        cpu_needs_bus = 1'b0;
        upper_address_limit = 16'h0BFF;
        lower_address_limit = 16'h0900;
        irq_sources = '0;
        cfg[0] = '0;
        cfg[1] = '0;
        rst_pulse();
        t_word();
        t_byte();
        t_trig();
        t_limit();
        t_cpu();
        collide(1'b0, 16'h0100);
        collide(1'b0, 16'h0100);
        rst_pulse();
        collide(1'b1, 16'h0100);
        collide(1'b1, 16'h0300);
        t_abort();
        results();
    end
endmodule : tcdma_test
